// >>> inc/otig_pkg.sv
package otig_pkg;
  // Register byte offsets.
  localparam logic [7:0] OTIG_CTRL_OFF = 8'h00;
  localparam logic [7:0] OTIG_EXT5_OFF = 8'h04;
  localparam logic [7:0] OTIG_STAT_OFF = 8'h08;
  localparam logic [7:0] OTIG_MASK_OFF = 8'h0C;
  localparam logic [7:0] OTIG_PINS_OFF = 8'h10;
  localparam logic [7:0] OTIG_ERR_OFF = 8'h14;
  // Control and EXT5 register fields and reset values.
  localparam int OTIG_CTRL_MODE_LSB = 0;
  localparam int OTIG_CTRL_SEQ_LSB = 4;
  localparam int OTIG_CTRL_CLR_BIT = 8;
  localparam logic [1:0] OTIG_MODE_RST = 2'h1;
  localparam logic [2:0] OTIG_SEQ_RST = 3'h0;
  localparam logic [15:0] OTIG_EXT5_RST = 16'h0000;
  localparam int OTIG_EXT5_HOME_BIT = 7;
  // Over-travel modes.
  localparam logic [1:0] OTIG_MODE_INHIBIT = 2'h0;
  localparam logic [1:0] OTIG_MODE_IGNORE = 2'h1;
  localparam logic [1:0] OTIG_MODE_ERROR = 2'h2;
  // Status and mask bit positions.
  localparam int OTIG_ST_OT_ERR = 0;
  localparam int OTIG_ST_HOME_ERR = 1;
  localparam int OTIG_ST_LIM_STOP = 2;
  localparam int OTIG_ST_W = 3;
  // Protective error codes.
  localparam logic [7:0] OTIG_OT_MAIN = 8'h26;
  localparam logic [3:0] OTIG_OT_SUB = 4'h0;
  localparam logic [7:0] OTIG_HOME_MAIN = 8'h5E;
  localparam logic [3:0] OTIG_HOME_SUB = 4'h3;
  // AHB encodings.
  localparam logic [1:0] OTIG_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] OTIG_HSIZE_WORD = 3'h2;
endpackage

// >>> hw/otig_guard.sv
`timescale 1ns/1ps
module otig_guard
  import otig_pkg::*;
#(
  parameter int TORQUE_W = 16
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic positive_limit_in,
  input wire logic negative_limit_in,
  input wire logic moving_cw,
  input wire logic moving_ccw,
  input wire logic profile_homing_active,
  input wire logic index_return_active,
  input wire logic index_return_abnormal,
  input wire logic signed [TORQUE_W-1:0] torque_cmd_in,
  output logic signed [TORQUE_W-1:0] torque_cmd_out,
  output logic stop_request,
  output logic [2:0] stop_sequence_out,
  output logic energize_enable,
  output logic protect_error,
  output logic [7:0] error_main,
  output logic [3:0] error_sub,
  output logic irq
);

  if (TORQUE_W < 2 || TORQUE_W > 32)
  begin : g_bad_width
    $error("TORQUE_W must lie between 2 and 32");
  end

  typedef struct packed {
    logic lim_p;
    logic lim_n;
    logic lim_any_prev;
    logic [1:0] mode;
    logic [2:0] stop_seq;
    logic [15:0] ext5;
    logic [OTIG_ST_W-1:0] status;
    logic [OTIG_ST_W-1:0] mask;
    logic err_latched;
    logic [7:0] err_main;
    logic [3:0] err_sub;
    logic energize;
    logic signed [TORQUE_W-1:0] torque_out;
    logic stop_req;
    logic [2:0] stop_seq_out;
    logic irq;
    logic [31:0] rdata;
    logic wr_pend;
    logic [7:0] wr_addr;
  } otig_state_t;

  otig_state_t s_q;
  otig_state_t s_d;

  logic [1:0] eff_mode;
  logic inhib_cw;
  logic inhib_ccw;
  logic ot_err_ev;
  logic home_err_ev;
  logic lim_stop_ev;
  logic addr_ok;
  logic [OTIG_ST_W-1:0] rd_clr;

  // Profile homing overrides the configured mode so the homing move is not
  // cut short by its own limit search.
  assign eff_mode = profile_homing_active ? OTIG_MODE_IGNORE : s_q.mode;
  assign inhib_cw = (eff_mode == OTIG_MODE_INHIBIT) && s_q.lim_p;
  assign inhib_ccw = (eff_mode == OTIG_MODE_INHIBIT) && s_q.lim_n;
  assign lim_stop_ev = (inhib_cw && moving_cw) || (inhib_ccw && moving_ccw);
  assign ot_err_ev = (eff_mode == OTIG_MODE_ERROR)
                     && (s_q.lim_p || s_q.lim_n);
  assign home_err_ev = (s_q.ext5[OTIG_EXT5_HOME_BIT] && index_return_active
                        && (s_q.lim_p || s_q.lim_n) && !s_q.lim_any_prev)
                       || index_return_abnormal;
  assign addr_ok = hsel && hready && (htrans == OTIG_HTRANS_NONSEQ)
                   && (hsize == OTIG_HSIZE_WORD);

  always_comb
  begin
    s_d = s_q;
    rd_clr = '0;
    s_d.lim_p = positive_limit_in;
    s_d.lim_n = negative_limit_in;
    s_d.lim_any_prev = s_q.lim_p || s_q.lim_n;

    // Zeroing only the inhibited sign lets the drive back off the limit.
    s_d.torque_out = torque_cmd_in;
    if ((inhib_cw && torque_cmd_in > 0) || (inhib_ccw && torque_cmd_in < 0))
    begin
      s_d.torque_out = '0;
    end
    s_d.stop_req = lim_stop_ev;
    s_d.stop_seq_out = s_q.stop_seq;

    // First protective error keeps its code until software clears it.
    if (!s_q.err_latched && home_err_ev)
    begin
      s_d.err_latched = 1'b1;
      s_d.err_main = OTIG_HOME_MAIN;
      s_d.err_sub = OTIG_HOME_SUB;
    end
    else if (!s_q.err_latched && ot_err_ev)
    begin
      s_d.err_latched = 1'b1;
      s_d.err_main = OTIG_OT_MAIN;
      s_d.err_sub = OTIG_OT_SUB;
    end
    if (home_err_ev)
    begin
      s_d.energize = 1'b0;
    end

    // Bus address phase: read data is prepared here so it is a flop output.
    s_d.wr_pend = addr_ok && hwrite;
    s_d.wr_addr = haddr[7:0];
    s_d.rdata = '0;
    if (addr_ok && !hwrite)
    begin
      unique case (haddr[7:0])
        OTIG_CTRL_OFF:
        begin
          s_d.rdata[OTIG_CTRL_MODE_LSB +: 2] = s_q.mode;
          s_d.rdata[OTIG_CTRL_SEQ_LSB +: 3] = s_q.stop_seq;
        end
        OTIG_EXT5_OFF: s_d.rdata[15:0] = s_q.ext5;
        OTIG_STAT_OFF:
        begin
          s_d.rdata[OTIG_ST_W-1:0] = s_q.status;
          rd_clr = s_q.status;
        end
        OTIG_MASK_OFF: s_d.rdata[OTIG_ST_W-1:0] = s_q.mask;
        OTIG_PINS_OFF:
          s_d.rdata[4:0] = {s_q.energize, inhib_ccw, inhib_cw,
                            s_q.lim_n, s_q.lim_p};
        OTIG_ERR_OFF:
          s_d.rdata[12:0] = {s_q.err_latched, s_q.err_sub, s_q.err_main};
        default: s_d.rdata = '0;
      endcase
    end

    // Data phase write. Mode 3 is not a legal setting and is dropped.
    if (s_q.wr_pend)
    begin
      unique case (s_q.wr_addr)
        OTIG_CTRL_OFF:
        begin
          if (hwdata[OTIG_CTRL_MODE_LSB +: 2] != 2'h3)
          begin
            s_d.mode = hwdata[OTIG_CTRL_MODE_LSB +: 2];
          end
          s_d.stop_seq = hwdata[OTIG_CTRL_SEQ_LSB +: 3];
          if (hwdata[OTIG_CTRL_CLR_BIT] && !home_err_ev && !ot_err_ev)
          begin
            s_d.err_latched = 1'b0;
            s_d.err_main = '0;
            s_d.err_sub = '0;
            s_d.energize = 1'b1;
          end
        end
        OTIG_EXT5_OFF: s_d.ext5 = hwdata[15:0];
        OTIG_MASK_OFF: s_d.mask = hwdata[OTIG_ST_W-1:0];
        default: s_d.mode = s_q.mode;
      endcase
    end

    // A new event in the clearing read cycle survives the clear.
    s_d.status = (s_q.status & ~rd_clr)
                 | {lim_stop_ev, home_err_ev, ot_err_ev};
    s_d.irq = |(s_d.status & s_q.mask);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_q <= '0;
      s_q.mode <= OTIG_MODE_RST;
      s_q.stop_seq <= OTIG_SEQ_RST;
      s_q.ext5 <= OTIG_EXT5_RST;
      s_q.energize <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign hrdata = s_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign torque_cmd_out = s_q.torque_out;
  assign stop_request = s_q.stop_req;
  assign stop_sequence_out = s_q.stop_seq_out;
  assign energize_enable = s_q.energize;
  assign protect_error = s_q.err_latched;
  assign error_main = s_q.err_main;
  assign error_sub = s_q.err_sub;
  assign irq = s_q.irq;

  sequence s_index_limit_rise;
    s_q.ext5[OTIG_EXT5_HOME_BIT] && index_return_active
      && (s_q.lim_p || s_q.lim_n) && !s_q.lim_any_prev;
  endsequence

  sequence s_home_err_shown;
    protect_error && !energize_enable;
  endsequence

  property p_sample;
    @(posedge hclk) disable iff (!hresetn)
      1'b1 |=> (s_q.lim_p == $past(positive_limit_in))
               && (s_q.lim_n == $past(negative_limit_in));
  endproperty
  a_sample: assert property (p_sample)
    else $error("limit inputs not sampled");

  property p_cw_zero;
    @(posedge hclk) disable iff (!hresetn)
      (!profile_homing_active && s_q.mode == OTIG_MODE_INHIBIT && s_q.lim_p
       && torque_cmd_in > 0) |=> torque_cmd_out == 0;
  endproperty
  a_cw_zero: assert property (p_cw_zero)
    else $error("CW torque not zero at positive limit");

  property p_ccw_zero;
    @(posedge hclk) disable iff (!hresetn)
      (!profile_homing_active && s_q.mode == OTIG_MODE_INHIBIT && s_q.lim_n
       && torque_cmd_in < 0) |=> torque_cmd_out == 0;
  endproperty
  a_ccw_zero: assert property (p_ccw_zero)
    else $error("CCW torque not zero at negative limit");

  property p_stop;
    @(posedge hclk) disable iff (!hresetn)
      (!profile_homing_active && s_q.mode == OTIG_MODE_INHIBIT && s_q.lim_p
       && moving_cw) |=> stop_request;
  endproperty
  a_stop: assert property (p_stop)
    else $error("no stop when moving into positive limit");

  property p_ignore;
    @(posedge hclk) disable iff (!hresetn)
      (eff_mode == OTIG_MODE_IGNORE)
        |=> !stop_request && torque_cmd_out == $past(torque_cmd_in);
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("limits acted while ignored");

  property p_suspend;
    @(posedge hclk) disable iff (!hresetn)
      profile_homing_active |=> !stop_request;
  endproperty
  a_suspend: assert property (p_suspend)
    else $error("stop requested during profile homing");

  property p_ot_err;
    @(posedge hclk) disable iff (!hresetn)
      (!protect_error && !home_err_ev && ot_err_ev)
        |=> protect_error && error_main == OTIG_OT_MAIN
            && error_sub == OTIG_OT_SUB;
  endproperty
  a_ot_err: assert property (p_ot_err)
    else $error("over-travel error not raised");

  property p_home_err;
    @(posedge hclk) disable iff (!hresetn)
      ((!protect_error) and s_index_limit_rise)
        |=> s_home_err_shown ##0 (error_main == OTIG_HOME_MAIN
            && error_sub == OTIG_HOME_SUB);
  endproperty
  a_home_err: assert property (p_home_err)
    else $error("index homing error not raised");

  property p_abnormal;
    @(posedge hclk) disable iff (!hresetn)
      index_return_abnormal |=> !energize_enable ##1 !energize_enable;
  endproperty
  a_abnormal: assert property (p_abnormal)
    else $error("abnormal return left energization on");
endmodule // otig_guard

// >>> bench/otig_far_side.sv
`timescale 1ns/1ps
// Limit switches and motion controller; pins move just after an edge.
module otig_far_side (
  input wire logic hclk,
  output logic positive_limit_in,
  output logic negative_limit_in,
  output logic moving_cw,
  output logic moving_ccw,
  output logic profile_homing_active,
  output logic index_return_active,
  output logic index_return_abnormal,
  output logic signed [15:0] torque_cmd_in
);
  initial
  begin
    {index_return_abnormal, index_return_active, profile_homing_active,
      moving_ccw, moving_cw, negative_limit_in, positive_limit_in} = 7'h00;
    torque_cmd_in = 16'sh0000;
  end
  // Limit pins are only ever raised where a limit switch is fitted.
  task automatic drive(input logic [6:0] p, input logic signed [15:0] t);
    {index_return_abnormal, index_return_active, profile_homing_active,
      moving_ccw, moving_cw, negative_limit_in, positive_limit_in} <= p;
    torque_cmd_in <= t;
  endtask
endmodule // otig_far_side

// >>> bench/otig_guard_bench.sv
`timescale 1ns/1ps
module otig_guard_bench import otig_pkg::*;;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, seq;
  logic signed [15:0] tq, tq_out;
  logic lp, ln, cw, ccw, hom, idx, abn, stp, ene, perr, irq;
  logic [7:0] emain;
  logic [3:0] esub;
  int num_errors, samples_checked, cycles;
  otig_far_side i_far (.hclk(hclk), .positive_limit_in(lp),
    .negative_limit_in(ln), .moving_cw(cw), .moving_ccw(ccw),
    .profile_homing_active(hom), .index_return_active(idx),
    .index_return_abnormal(abn), .torque_cmd_in(tq));
  otig_guard i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .positive_limit_in(lp),
    .negative_limit_in(ln), .moving_cw(cw), .moving_ccw(ccw),
    .profile_homing_active(hom), .index_return_active(idx),
    .index_return_abnormal(abn), .torque_cmd_in(tq),
    .torque_cmd_out(tq_out), .stop_request(stp), .stop_sequence_out(seq),
    .energize_enable(ene), .protect_error(perr), .error_main(emain),
    .error_sub(esub), .irq(irq));
  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  task automatic finish_test;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge hclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      num_errors++;
      finish_test;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e, string m);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  // Holds each phase until hready is seen high, as AHB-Lite requires.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= OTIG_HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, string m);
    bus(1'b0, a, 32'h00000000);
    chk(rd, e, m);
  endtask
  // Outputs follow a limit pin change two edges later, and a change on the other pins or the torque one edge later.
  task automatic pins(input logic [6:0] p, input logic signed [15:0] t);
    @(posedge hclk);
    i_far.drive(p, t);
    repeat (3) @(posedge hclk);
  endtask
  task automatic t_reset;
    rdchk(OTIG_CTRL_OFF, 32'h00000001, "ctrl reset");
    rdchk(OTIG_EXT5_OFF, 32'h00000000, "ext5 reset");
    rdchk(8'h20, 32'h00000000, "unmapped read");
    rdchk(OTIG_PINS_OFF, 32'h00000010, "pins reset");
    chk(hresp, 32'h00000000, "okay response");
    chk(ene, 32'h00000001, "energize after reset");
    $display("test reset done");
  endtask
  task automatic t_ignore;
    pins(7'h07, 16'sh0064);
    chk(tq_out, 16'sh0064, "torque in ignore");
    chk({stp, perr}, 32'h00000000, "stop or error in ignore");
    $display("test ignore done");
  endtask
  task automatic t_inhibit;
    bus(1'b1, OTIG_CTRL_OFF, 32'h00000053);
    rdchk(OTIG_CTRL_OFF, 32'h00000051, "mode 3 refused");
    bus(1'b1, OTIG_CTRL_OFF, 32'h00000050);
    pins(7'h05, 16'sh0064);
    chk({stp, seq}, 32'h0000000D, "cw stop");
    chk(tq_out, 32'h00000000, "cw torque");
    rdchk(OTIG_PINS_OFF, 32'h00000015, "pins cw inhibit");
    pins(7'h01, 16'shFF9C);
    chk(tq_out, 16'shFF9C, "ccw torque at cw limit");
    pins(7'h0A, 16'shFF9C);
    chk({stp, tq_out}, 32'h00010000, "ccw stop and torque");
    pins(7'h02, 16'sh0064);
    chk({stp, tq_out}, 32'h00000064, "cw free at ccw limit");
    $display("test inhibit done");
  endtask
  task automatic t_error;
    pins(7'h00, 16'sh0000);
    bus(1'b0, OTIG_STAT_OFF, 32'h00000000);
    bus(1'b1, OTIG_CTRL_OFF, 32'h00000002);
    pins(7'h02, 16'sh0000);
    chk({perr, emain, esub}, 32'h00001260, "code 38.0");
    chk(irq, 32'h00000000, "masked irq");
    bus(1'b1, OTIG_MASK_OFF, 32'h00000001);
    repeat (2) @(posedge hclk);
    chk(irq, 32'h00000001, "unmasked irq");
    rdchk(OTIG_MASK_OFF, 32'h00000001, "mask readback");
    rdchk(OTIG_ERR_OFF, 32'h00001026, "err register");
    pins(7'h00, 16'sh0000);
    rdchk(OTIG_STAT_OFF, 32'h00000001, "status event");
    rdchk(OTIG_STAT_OFF, 32'h00000000, "status cleared");
    repeat (2) @(posedge hclk);
    chk(irq, 32'h00000000, "irq cleared");
    $display("test error done");
  endtask
  task automatic t_home;
    bus(1'b1, OTIG_CTRL_OFF, 32'h00000100);
    bus(1'b1, OTIG_EXT5_OFF, 32'h00000080);
    pins(7'h34, 16'sh0064);
    pins(7'h35, 16'sh0064);
    chk({stp, tq_out}, 32'h00000064, "inhibit suspended");
    chk({perr, emain, esub}, 32'h000015E3, "code 94.3");
    chk(ene, 32'h00000000, "energize cut");
    pins(7'h00, 16'sh0000);
    bus(1'b1, OTIG_CTRL_OFF, 32'h00000100);
    repeat (2) @(posedge hclk);
    chk({ene, perr}, 32'h00000002, "error cleared");
    bus(1'b1, OTIG_EXT5_OFF, 32'h0000007F);
    pins(7'h30, 16'sh0000);
    pins(7'h31, 16'sh0000);
    chk(perr, 32'h00000000, "check disabled");
    pins(7'h00, 16'sh0000);
    bus(1'b1, OTIG_EXT5_OFF, 32'h00000080);
    pins(7'h70, 16'sh0000);
    chk({perr, emain, esub}, 32'h000015E3, "abnormal return");
    $display("test home done");
  endtask
  initial
  begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = OTIG_HSIZE_WORD;
    num_errors = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_ignore;
    t_inhibit;
    t_error;
    t_home;
    finish_test;
  end
endmodule // otig_guard_bench
